/* common/twp_pkg.sv */
// Purpose: Shared constants and types for the three-wire clocked serial port.
// Assumes: APB with 32-bit data; one word per register.
// Notes:   Register index times four gives the byte address.
package twp_pkg;

   // Bus widths
   localparam int          PADDR_W        = 18;
   localparam int          PDATA_W        = 32;

   // Register indexes; the byte address is the index times four
   localparam logic [15:0] MODE_IDX       = 16'hffb0; // serial_mode_control
   localparam logic [15:0] CLKSEL_IDX     = 16'hffb1; // serial_clock_select
   localparam logic [15:0] TXBUF_IDX      = 16'hffb2; // transmit_buffer
   localparam logic [15:0] SHIFT_IDX      = 16'hffb3; // serial_shift_register
   localparam logic [15:0] STATUS_IDX     = 16'hffb4; // transfer_done_irq_flag

   localparam logic [PADDR_W-1:0] MODE_ADDR   = {MODE_IDX, 2'h0};
   localparam logic [PADDR_W-1:0] CLKSEL_ADDR = {CLKSEL_IDX, 2'h0};
   localparam logic [PADDR_W-1:0] TXBUF_ADDR  = {TXBUF_IDX, 2'h0};
   localparam logic [PADDR_W-1:0] SHIFT_ADDR  = {SHIFT_IDX, 2'h0};
   localparam logic [PADDR_W-1:0] STATUS_ADDR = {STATUS_IDX, 2'h0};

   // Mode register fields
   localparam int          MODE_EN_BIT    = 7;  // port_enable_bit
   localparam int          MODE_TRMD_BIT  = 6;  // transmit_mode_bit
   localparam int          MODE_SSE_BIT   = 5;  // slave_select_use_bit
   localparam int          MODE_DIR_BIT   = 4;  // bit_order_bit
   localparam int          MODE_BUSY_BIT  = 0;  // busy_flag, read-only
   localparam logic [7:0]  MODE_RST       = 8'h00;

   // Clock select register fields
   localparam int          CLK_CKP_BIT    = 4;  // clock_polarity_bit
   localparam int          CLK_DAP_BIT    = 3;  // data_phase_bit
   localparam int          CLK_CKS_LSB    = 0;  // clock_select_bit2..0
   localparam logic [7:0]  CLKSEL_RST     = 8'h10;
   localparam logic [2:0]  CKS_EXTERNAL   = 3'h7;

   // Status register field
   localparam int          STAT_DONE_BIT  = 0;

   // Transfer shape: eight bits, two clock edges per bit
   localparam logic [3:0]  LAST_EDGE      = 4'hf;
   localparam int          DIV_W          = 6;

   // Engine states, one-hot
   typedef enum logic [2:0] {
      TWP_IDLE = 3'h1,
      TWP_PEND = 3'h2,
      TWP_RUN  = 3'h4
   } twp_state_t;

   // Pin drive bundle
   typedef struct packed {
      logic sck_out;   // serial_clock_pin level
      logic sck_oe;    // serial_clock_pin driven
      logic so_out;    // serial_out_pin level
      logic so_oe;     // serial_out_pin driven
   } twp_pins_t;

   // Whole state of the port
   typedef struct packed {
      twp_state_t         st;
      logic               en;
      logic               trmd;
      logic               sse;
      logic               dir;
      logic               ckp;
      logic               dap;
      logic [2:0]         cks;
      logic [7:0]         txbuf;
      logic [7:0]         sreg;
      logic               pend_tx;
      logic               rx_bit;
      logic               so_q;
      logic               busy;
      logic               done;
      logic [3:0]         hcnt;
      logic [DIV_W-1:0]   div;
      logic               sck_lvl;
      logic               sck_prev;
      twp_pins_t          pins;
      logic               pready;
      logic               pslverr;
      logic [PDATA_W-1:0] prdata;
   } twp_state_s_t;

endpackage : twp_pkg

/* hw/twp_port.sv */
// Purpose: Three-wire clocked serial port with an APB register slave.
// Assumes: Pin inputs synchronous to pclk; pclk at 25 MHz.
// Notes:   Master on an internal divided clock, slave on the pin clock.
`timescale 1ns/10ps

// Function
// - Every transfer moves exactly eight clocked bits
// - Mode bit 6 selects transmit, else receive
// - Transmit buffer write starts transmit transfer
// - Shift register read starts a receive transfer
// - Selected slave waits while select high
// - Busy flag set once transfer begins
// - After eighth bit set done, clear busy
// - Busy flag is read-only to software
// - Clearing enable clears busy, stops operation
// - Receive-only mode drives serial output low
// - Clock select divides by two to 128, external
// - Polarity and phase bits give four types
// - Clock select resets to 10H, type 3
// - First bit presented at start per phase
// - Output keeps last bit after transfer
// - Disabled clock pin high, low for internal polarity
// - Disabled output pin level by mode and phase
// - Mode, phase, order writes change output at once
// - Enable activates pins; disabled frees them
// - Select rising during transfer aborts it
// - Mode register resets to 00H
module twp_port
   import twp_pkg::*;
(
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [PADDR_W-1:0] paddr,
   input  wire logic [PDATA_W-1:0] pwdata,
   output logic      [PDATA_W-1:0] prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire logic               serial_clock_pin_in,
   input  wire logic               serial_in_pin,
   input  wire logic               slave_select_n,
   output twp_pins_t               pin_drive,
   output logic                    transfer_done_irq_flag
);

   // Bit that leaves first, chosen by bit order
   function automatic logic first_bit(input logic [7:0] d, input logic lsb_first);
      first_bit = lsb_first ? d[0] : d[7];
   endfunction : first_bit

   // One shift step with a new bit entering at the far end
   function automatic logic [7:0] shift_in(input logic [7:0] d, input logic lsb_first,
                                           input logic b);
      shift_in = lsb_first ? {b, d[7:1]} : {d[6:0], b};
   endfunction : shift_in

   // Divider mask: half serial period is 2^cks pclk cycles
   function automatic logic [DIV_W-1:0] half_mask(input logic [2:0] cks);
      half_mask = DIV_W'((7'h1 << cks) - 7'h1);
   endfunction : half_mask

   twp_state_s_t s;        // Registered state
   twp_state_s_t next_s;   // Next state

   // Bus decode terms
   logic bus_done;         // Access completes this edge
   logic wr_mode;          // Write to mode register
   logic wr_clk;           // Write to clock select
   logic wr_tx;            // Write to transmit buffer
   logic wr_stat;          // Write to status register
   logic rd_shift;         // Read of shift register
   logic start_tx;         // Transmit start request
   logic start_rx;         // Receive start request
   logic ext_clk;          // External clock selected
   logic blocked;          // Slave not selected
   logic tick;             // Master half-period pulse
   logic edge_ev;          // One serial clock edge
   logic lead;             // Edge is the leading one of a bit

   assign bus_done = psel & penable & s.pready;
   assign wr_mode  = bus_done & pwrite & (paddr == MODE_ADDR);
   assign wr_clk   = bus_done & pwrite & (paddr == CLKSEL_ADDR);
   assign wr_tx    = bus_done & pwrite & (paddr == TXBUF_ADDR);
   assign wr_stat  = bus_done & pwrite & (paddr == STATUS_ADDR);
   assign rd_shift = bus_done & ~pwrite & (paddr == SHIFT_ADDR);
   assign start_tx = wr_tx & s.en & s.trmd;
   assign start_rx = rd_shift & s.en;
   assign ext_clk  = (s.cks == CKS_EXTERNAL);
   assign blocked  = ext_clk & s.sse & slave_select_n;
   assign tick     = ((s.div & half_mask(s.cks)) == half_mask(s.cks));
   // Master steps on the divider, slave on any pin clock transition
   assign edge_ev  = ext_clk ? (serial_clock_pin_in != s.sck_prev) : tick;
   assign lead     = ~s.hcnt[0];

   // Next state: bus slave, register file, transfer engine, pin levels
   always_comb begin
      next_s          = s;
      next_s.pready   = 1'b0;
      next_s.pslverr  = 1'b0;
      next_s.sck_prev = serial_clock_pin_in;

      // Access phase: one wait cycle, then answer with data or error
      if (psel & penable & ~s.pready) begin
         next_s.pready = 1'b1;
         next_s.prdata = '0;
         case (paddr)
            MODE_ADDR: begin
               next_s.prdata[MODE_EN_BIT]   = s.en;
               next_s.prdata[MODE_TRMD_BIT] = s.trmd;
               next_s.prdata[MODE_SSE_BIT]  = s.sse;
               next_s.prdata[MODE_DIR_BIT]  = s.dir;
               next_s.prdata[MODE_BUSY_BIT] = s.busy;
            end
            CLKSEL_ADDR: begin
               next_s.prdata[CLK_CKP_BIT]             = s.ckp;
               next_s.prdata[CLK_DAP_BIT]             = s.dap;
               next_s.prdata[CLK_CKS_LSB +: 3]        = s.cks;
            end
            TXBUF_ADDR:  next_s.prdata[7:0] = s.txbuf;
            SHIFT_ADDR:  next_s.prdata[7:0] = s.sreg;
            STATUS_ADDR: next_s.prdata[STAT_DONE_BIT] = s.done;
            default:     next_s.pslverr = 1'b1;   // Unmapped address
         endcase
      end

      // Register writes; busy is never taken from the bus
      if (wr_mode) begin
         next_s.en   = pwdata[MODE_EN_BIT];
         next_s.trmd = pwdata[MODE_TRMD_BIT];
         next_s.sse  = pwdata[MODE_SSE_BIT];
         next_s.dir  = pwdata[MODE_DIR_BIT];
      end
      if (wr_clk) begin
         next_s.ckp = pwdata[CLK_CKP_BIT];
         next_s.dap = pwdata[CLK_DAP_BIT];
         next_s.cks = pwdata[CLK_CKS_LSB +: 3];
      end
      if (wr_tx) begin
         next_s.txbuf = pwdata[7:0];
      end
      // Software clear of the done flag; a set below wins the same cycle
      if (wr_stat & pwdata[STAT_DONE_BIT]) begin
         next_s.done = 1'b0;
      end

      // Master divider runs only while shifting
      next_s.div = (s.st == TWP_RUN) ? s.div + DIV_W'(1) : '0;

      case (s.st)
         // Waiting for software to ask for a transfer
         TWP_IDLE: begin
            if (start_tx | start_rx) begin
               next_s.pend_tx = start_tx;
               if (blocked) begin
                  next_s.st = TWP_PEND;
               end else begin
                  next_s.st     = TWP_RUN;
                  next_s.busy   = 1'b1;
                  next_s.hcnt   = '0;
                  next_s.div    = '0;
                  next_s.sreg   = start_tx ? pwdata[7:0] : s.sreg;
                  if (s.dap) begin
                     next_s.so_q = first_bit(start_tx ? pwdata[7:0] : s.sreg, s.dir);
                  end
               end
            end
         end
         // Start held until the slave is selected
         TWP_PEND: begin
            if (~blocked) begin
               next_s.st   = TWP_RUN;
               next_s.busy = 1'b1;
               next_s.hcnt = '0;
               next_s.div  = '0;
               next_s.sreg = s.pend_tx ? s.txbuf : s.sreg;
               if (s.dap) begin
                  next_s.so_q = first_bit(s.pend_tx ? s.txbuf : s.sreg, s.dir);
               end
            end
         end
         // Shifting: sixteen edges, two per bit
         TWP_RUN: begin
            if (blocked) begin
               // Deselect mid-transfer drops it with no done flag
               next_s.st   = TWP_IDLE;
               next_s.busy = 1'b0;
            end else if (edge_ev) begin
               next_s.hcnt = s.hcnt + 4'h1;
               if (~ext_clk) begin
                  next_s.sck_lvl = ~s.sck_lvl;
               end
               if (lead) begin
                  // Phase 0 drives on the leading edge, phase 1 samples there
                  if (~s.dap) begin
                     next_s.so_q = first_bit(s.sreg, s.dir);
                  end else begin
                     next_s.rx_bit = serial_in_pin;
                  end
               end else begin
                  next_s.sreg = shift_in(s.sreg, s.dir, s.dap ? s.rx_bit : serial_in_pin);
                  // Last bit stays on the pin once the byte is out
                  if (s.dap && (s.hcnt != LAST_EDGE)) begin
                     next_s.so_q = first_bit(shift_in(s.sreg, s.dir, s.rx_bit), s.dir);
                  end
                  if (s.hcnt == LAST_EDGE) begin
                     next_s.st   = TWP_IDLE;
                     next_s.busy = 1'b0;
                     next_s.done = 1'b1;
                  end
               end
            end
         end
         default: begin
            next_s.st   = TWP_IDLE;
            next_s.busy = 1'b0;
         end
      endcase

      // Disabling the port stops everything and drops busy
      if (~next_s.en) begin
         next_s.st   = TWP_IDLE;
         next_s.busy = 1'b0;
      end
      // Clock rests at the polarity's idle level outside a transfer
      if (next_s.st != TWP_RUN) begin
         next_s.sck_lvl = ~next_s.ckp;
      end

      // Pin levels follow the next state so that they come from flops
      next_s.pins.sck_oe = next_s.en & (next_s.cks != CKS_EXTERNAL);
      if (next_s.en) begin
         next_s.pins.sck_out = (next_s.cks == CKS_EXTERNAL) ? 1'b1 : next_s.sck_lvl;
      end else begin
         next_s.pins.sck_out = ~(next_s.ckp & (next_s.cks != CKS_EXTERNAL));
      end
      next_s.pins.so_oe = next_s.en;
      if (~next_s.trmd) begin
         next_s.pins.so_out = 1'b0;
      end else if (next_s.en | ~next_s.dap) begin
         next_s.pins.so_out = next_s.so_q;
      end else begin
         next_s.pins.so_out = first_bit(next_s.txbuf, next_s.dir);
      end
   end

   // State register; reset leaves mode 00H and clock select 10H
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s          <= '0;
         s.st       <= TWP_IDLE;
         s.ckp      <= CLKSEL_RST[CLK_CKP_BIT];
         s.dap      <= CLKSEL_RST[CLK_DAP_BIT];
         s.cks      <= CLKSEL_RST[CLK_CKS_LSB +: 3];
         s.en       <= MODE_RST[MODE_EN_BIT];
         s.trmd     <= MODE_RST[MODE_TRMD_BIT];
         s.sse      <= MODE_RST[MODE_SSE_BIT];
         s.dir      <= MODE_RST[MODE_DIR_BIT];
         s.sck_lvl  <= 1'b0;
         s.pins     <= '0;   // Clock low at reset matches polarity 1, internal
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state flops
   assign prdata                 = s.prdata;
   assign pready                 = s.pready;
   assign pslverr                = s.pslverr;
   assign pin_drive              = s.pins;
   assign transfer_done_irq_flag = s.done;

   // Checks beside the logic
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   busy_on_start_a: assert property (
      (s.st == TWP_IDLE) && start_tx && !blocked && !wr_mode |=> s.busy && s.st == TWP_RUN)
      else $error("busy not set after transfer start");

   tx_load_a: assert property (
      (s.st == TWP_IDLE) && start_tx && !blocked |=> s.sreg == $past(pwdata[7:0]))
      else $error("transmit byte not loaded");

   done_ends_busy_a: assert property (
      $rose(s.done) |-> !s.busy && s.st == TWP_IDLE)
      else $error("done flag set while still busy");

   eight_bits_a: assert property (
      $rose(s.done) |-> $past(s.hcnt) == LAST_EDGE && $past(s.st) == TWP_RUN)
      else $error("transfer ended before sixteen edges");

   busy_readonly_a: assert property (
      wr_mode && !s.busy && pwdata[MODE_BUSY_BIT] |=> !s.busy)
      else $error("busy flag taken from a write");

   disable_stops_a: assert property (
      wr_mode && !pwdata[MODE_EN_BIT] |=> !s.busy && s.st == TWP_IDLE)
      else $error("disable did not stop the port");

   rx_only_low_a: assert property (
      !s.trmd |-> !pin_drive.so_out)
      else $error("serial output not low in receive-only mode");

   pending_idle_a: assert property (
      s.st == TWP_PEND |-> !s.busy)
      else $error("busy while waiting for select");

   deselect_abort_a: assert property (
      s.st == TWP_RUN && blocked |=> s.st == TWP_IDLE && !s.busy && !$rose(s.done))
      else $error("deselect did not abort transfer");

   sck_disabled_a: assert property (
      !s.en |-> pin_drive.sck_out == !(s.ckp && !ext_clk))
      else $error("wrong clock pin level while disabled");

   so_disabled_a: assert property (
      !s.en && s.trmd && s.dap |-> pin_drive.so_out == first_bit(s.txbuf, s.dir))
      else $error("wrong output pin level while disabled");

   rx_start_a: assert property (
      (s.st == TWP_IDLE) && start_rx && !blocked |=> s.busy && s.st == TWP_RUN)
      else $error("receive did not start on shift read");

   no_tx_start_a: assert property (
      (s.st == TWP_IDLE) && wr_tx && !s.trmd |=> !s.busy && s.st == TWP_IDLE)
      else $error("transmit started in receive-only mode");

   pend_hold_a: assert property (
      s.st == TWP_PEND && blocked && !wr_mode |=> s.st == TWP_PEND)
      else $error("start left pending state while deselected");

   tx_done_c:   cover property ($rose(s.done) && s.trmd);
   rx_done_c:   cover property ($rose(s.done) && !s.trmd);
   pend_run_c:  cover property (s.st == TWP_PEND ##1 s.st == TWP_RUN);
   abort_c:     cover property (s.st == TWP_RUN && blocked);
   type4_c:     cover property ($rose(s.done) && s.ckp && s.dap);

endmodule : twp_port

/* tb/twp_partner.sv */
// Purpose: Far-side peripheral facing the port while the port is master.
// Assumes: Type 1 phase: data moves on the falling clock, sampled on rising.
// Notes:   Edges seen while the port does not drive the clock are ignored.
`timescale 1ns/10ps
module twp_partner
   import twp_pkg::*;
(
   input  wire logic       load,
   input  wire logic [7:0] tx_byte,
   input  wire twp_pins_t  pins,
   output logic            si,
   output logic [7:0]      rx_byte,
   output logic [3:0]      n_rise
);
   logic [7:0] sh; // Bits still to send

   // Fresh byte; the idle line flips so a stale level never passes as data
   always @(posedge load) begin
      sh     = tx_byte;
      si     = ~si;
      n_rise = 4'h0;
   end

   // Leading edge: present the next bit, MSB first
   always @(negedge pins.sck_out) begin
      if (pins.sck_oe) begin
         si = sh[7];
         sh = {sh[6:0], 1'b0};
      end
   end

   // Trailing edge: sample what the port shifts out
   always @(posedge pins.sck_out) begin
      if (pins.sck_oe) begin
         rx_byte = {rx_byte[6:0], pins.so_out};
         n_rise  = n_rise + 4'h1;
      end
   end

   // Known levels before the first frame
   initial begin
      si      = 1'b0;
      sh      = 8'h00;
      rx_byte = 8'h00;
      n_rise  = 4'h0;
   end
endmodule : twp_partner

/* tb/tb_twp_port.sv */
// Purpose: Self-checking bench for the three-wire port over APB.
// Assumes: Registers reached by byte address; one wait state per access.
// Notes:   Slave clocking is only touched lightly; select abort is the focus.
`timescale 1ns/10ps
module tb_twp_port;
   import twp_pkg::*;
   logic               pclk, presetn, psel, penable, pwrite;
   logic [PADDR_W-1:0] paddr;
   logic [PDATA_W-1:0] pwdata, prdata;
   logic               pready, pslverr, sck_in, ssel_n, si, done_flag;
   logic               p_load, sck_last, err;
   twp_pins_t          pins;
   logic [7:0]         p_tx, p_rx;
   logic [3:0]         p_rise;
   logic [31:0]        rd;
   int                 n_fail, checks_done, gap, run;

   twp_port uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .serial_clock_pin_in(sck_in),
      .serial_in_pin(si), .slave_select_n(ssel_n), .pin_drive(pins),
      .transfer_done_irq_flag(done_flag));
   twp_partner peer (.load(p_load), .tx_byte(p_tx), .pins(pins), .si(si),
      .rx_byte(p_rx), .n_rise(p_rise));

   // Clock at 25 MHz
   always #20 pclk = ~pclk;

   // Cycles between serial clock transitions, to judge the divider
   always @(posedge pclk) begin
      if (pins.sck_out !== sck_last) begin
         gap <= run;
         run <= 1;
      end else begin
         run <= run + 1;
      end
      sck_last <= pins.sck_out;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   // One APB transfer; held until pready, then one idle cycle
   task automatic apb(input logic wr, input logic [PADDR_W-1:0] a, input logic [31:0] wd);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic load_peer(input logic [7:0] b);
      p_tx   <= b;
      @(posedge pclk);
      p_load <= 1'b1;
      @(posedge pclk);
      p_load <= 1'b0;
   endtask : load_peer

   // Waits for completion under a bound, then clears the sticky flag
   task automatic wait_done();
      int k;
      k = 0;
      while (done_flag !== 1'b1 && k < 3000) begin
         @(posedge pclk);
         k++;
      end
      check(32'(done_flag), 32'h1, "done flag");
      apb(1'b0, MODE_ADDR, 32'h0);
      check(32'(rd[0]), 32'h0, "busy after transfer");
      apb(1'b1, STATUS_ADDR, 32'h1);
   endtask : wait_done

   task automatic pins_are(input logic [3:0] exp, input string what);
      repeat (3) @(posedge pclk);
      check(32'(pins), 32'(exp), what);
   endtask : pins_are

   task automatic t_reset();
      apb(1'b0, MODE_ADDR, 32'h0);
      check(rd, 32'h0, "mode reset");
      apb(1'b0, CLKSEL_ADDR, 32'h0);
      check(rd, 32'h10, "clock select reset");
      pins_are(4'h0, "pins after reset");
   endtask : t_reset

   task automatic t_regs();
      apb(1'b1, MODE_ADDR, 32'h81);
      apb(1'b0, MODE_ADDR, 32'h0);
      check(rd, 32'h80, "busy bit written");
      check(32'(pins.sck_oe), 32'h1, "clock driven when enabled");
      apb(1'b0, STATUS_ADDR + 18'h4, 32'h0);
      check({rd[30:0], err}, 32'h1, "unmapped read");
   endtask : t_regs

   task automatic t_tx();
      apb(1'b1, MODE_ADDR, 32'hc0);
      apb(1'b1, CLKSEL_ADDR, 32'h01);
      load_peer(8'h3c);
      apb(1'b1, TXBUF_ADDR, 32'ha5);
      apb(1'b0, MODE_ADDR, 32'h0);
      check(32'(rd[0]), 32'h1, "busy during transfer");
      wait_done();
      check(32'(p_rx), 32'ha5, "byte shifted out");
      check(32'(p_rise), 32'h8, "clock count");
      check(32'(gap), 32'h2, "half period");
      check(32'(pins.so_out), 32'h1, "last bit held");
   endtask : t_tx

   task automatic t_rx();
      apb(1'b1, MODE_ADDR, 32'h80);
      pins_are(4'b1101, "receive-only output low");
      apb(1'b1, TXBUF_ADDR, 32'h55);
      apb(1'b0, MODE_ADDR, 32'h0);
      check(32'(rd[0]), 32'h0, "no start in receive mode");
      load_peer(8'h96);
      apb(1'b0, SHIFT_ADDR, 32'h0);
      check(rd, 32'h3c, "byte received in transmit");
      wait_done();
      check(32'(p_rise), 32'h8, "receive clock count");
      apb(1'b0, SHIFT_ADDR, 32'h0);
      check(rd, 32'h96, "byte received");
      wait_done();
   endtask : t_rx

   // Type 4, LSB first: first bit out at start, moved on falling, sampled on rising
   task automatic t_type4();
      apb(1'b1, CLKSEL_ADDR, 32'h18);
      apb(1'b1, MODE_ADDR, 32'hd0);
      load_peer(8'h0f);
      apb(1'b1, TXBUF_ADDR, 32'h03);
      wait_done();
      check(32'(p_rx), 32'hc0, "lsb-first byte out");
      check(32'(p_rise), 32'h8, "type 4 clock count");
      check(32'(gap), 32'h1, "fastest half period");
      check(32'(pins.so_out), 32'h0, "last lsb-first bit held");
      apb(1'b1, MODE_ADDR, 32'h80);
   endtask : t_type4

   task automatic t_pins();
      apb(1'b1, CLKSEL_ADDR, 32'h08);
      apb(1'b1, TXBUF_ADDR, 32'h80);
      apb(1'b1, MODE_ADDR, 32'h40);
      pins_are(4'b1010, "idle out msb");
      apb(1'b1, MODE_ADDR, 32'h50);
      pins_are(4'b1000, "idle out lsb");
      apb(1'b1, MODE_ADDR, 32'h80);
      apb(1'b1, CLKSEL_ADDR, 32'h10);
      apb(1'b1, MODE_ADDR, 32'h00);
      pins_are(4'b0000, "idle clock low");
      apb(1'b1, MODE_ADDR, 32'h80);
      apb(1'b1, CLKSEL_ADDR, 32'h17);
      apb(1'b1, MODE_ADDR, 32'h00);
      pins_are(4'b1000, "idle clock external");
   endtask : t_pins

   task automatic t_disable();
      apb(1'b1, MODE_ADDR, 32'hc0);
      apb(1'b1, CLKSEL_ADDR, 32'h06);
      apb(1'b1, TXBUF_ADDR, 32'hff);
      apb(1'b1, MODE_ADDR, 32'h00);
      apb(1'b0, MODE_ADDR, 32'h0);
      check(rd, 32'h0, "busy cleared by disable");
      check(32'(done_flag), 32'h0, "no done on disable");
   endtask : t_disable

   task automatic t_slave();
      apb(1'b1, MODE_ADDR, 32'he0);
      apb(1'b1, CLKSEL_ADDR, 32'h07);
      apb(1'b1, TXBUF_ADDR, 32'h5a);
      apb(1'b0, MODE_ADDR, 32'h0);
      check(rd, 32'he0, "start pends while deselected");
      check(32'(pins.sck_oe), 32'h0, "slave leaves clock");
      ssel_n <= 1'b0;
      repeat (6) @(posedge pclk);
      apb(1'b0, MODE_ADDR, 32'h0);
      check(rd, 32'he1, "start on select");
      repeat (2) begin
         repeat (4) @(posedge pclk);
         sck_in <= ~sck_in;
      end
      ssel_n <= 1'b1;
      repeat (4) @(posedge pclk);
      apb(1'b0, MODE_ADDR, 32'h0);
      check(rd, 32'he0, "abort on deselect");
      check(32'(done_flag), 32'h0, "no done on abort");
   endtask : t_slave

   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : complete_run

   // Main sequence
   initial begin
      {pclk, presetn, psel, penable, pwrite, p_load} = 6'h0;
      {sck_in, ssel_n, sck_last} = 3'h7;
      paddr = '0;
      pwdata = '0;
      p_tx = 8'h00;
      n_fail = 0;
      checks_done = 0;
      gap = 0;
      run = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_regs();
      t_tx();
      t_rx();
      t_type4();
      t_pins();
      t_disable();
      t_slave();
      complete_run();
   end

   // Watchdog, well beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      complete_run();
   end
endmodule : tb_twp_port
